// ===== design/cio_top.sv
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module cio_top #(
  parameter int DEBOUNCE_CYCLES = cio_pkg::DEBOUNCE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pattern_sel_bit0,
  input wire logic pattern_sel_bit1,
  input wire logic pattern_sel_bit2,
  input wire logic pattern_sel_bit3,
  input wire logic run_contact,
  input wire logic stop_contact,
  input wire logic cascade_local_contact,
  input wire logic pattern_offset_contact,
  output logic pv_event_a_out,
  output logic pv_event_b_out,
  output logic instrument_alarm_out,
  output logic time_event_a_out,
  output logic time_event_b_out,
  output logic time_event_c_out,
  output logic time_event_d_out,
  output logic [4:0] pattern_number,
  output logic program_running,
  output logic cascade_mode,
  output logic [15:0] control_output_value,
  output logic [15:0] retrans_first_value,
  output logic retrans_first_en,
  output logic loop_power_first_en,
  output logic [15:0] retrans_second_value,
  output logic retrans_second_en,
  output logic loop_power_second_en,
  output logic [15:0] pid1_p,
  output logic [15:0] pid1_i,
  output logic [15:0] pid1_d,
  output logic [15:0] pid2_p,
  output logic [15:0] pid2_i,
  output logic [15:0] pid2_d,
  output logic irq
);
  logic [7:0] raw_di;
  logic [7:0] db;
  logic [7:0] db_prev_r;
  logic run_rise, stop_rise, start_req, stop_req;
  cio_pkg::cio_state_t st_r, st_nxt;
  logic [4:0] pattern_nxt;
  logic aw_have_r, w_have_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write, wr_err;
  logic [31:0] rd_word;
  logic rd_err;
  logic key_run_r, key_stop_r, manual_r, kind_relay_r;
  logic [2:0] retrans_first_type_type_r, retrans_second_type_type_r;
  logic [15:0] preset_r, manual_val_r, pv_r, sp_r, pid_out_r;
  logic [6:0] events_r;
  logic [2:0] grp1_r, grp2_r;
  logic [15:0] pid_mem [64];
  logic [cio_pkg::IRQ_W-1:0] irq_stat_r, irq_en_r, irq_set, irq_clr;

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction

  assign raw_di = {pattern_offset_contact, cascade_local_contact, stop_contact, run_contact,
                   pattern_sel_bit3, pattern_sel_bit2, pattern_sel_bit1, pattern_sel_bit0};
  cio_debounce #(.W(8), .CNT_W(cio_pkg::DB_CNT_W), .CYC(DEBOUNCE_CYCLES)) u_db (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(raw_di),
    .clean_out(db)
  );

  // edge detect on clean levels only
  always_ff @(posedge aclk) begin
    if (!aresetn) db_prev_r <= 8'h00;
    else db_prev_r <= db;
  end
  assign run_rise = db[4] & ~db_prev_r[4];
  assign stop_rise = db[5] & ~db_prev_r[5];
  assign start_req = run_rise | key_run_r;
  assign stop_req = stop_rise | key_stop_r;

  // run/idle sequencing; a stop in the same cycle as a start wins
  always_comb begin
    case (st_r)
      cio_pkg::CIO_ST_IDLE: st_nxt = (start_req && !stop_req) ? cio_pkg::CIO_ST_RUN : st_r;
      cio_pkg::CIO_ST_RUN: st_nxt = stop_req ? cio_pkg::CIO_ST_IDLE : st_r;
      default: st_nxt = cio_pkg::CIO_ST_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) st_r <= cio_pkg::CIO_ST_IDLE;
    else st_r <= st_nxt;
  end

  assign pattern_nxt = {1'b0, db[3:0]} + (db[7] ? cio_pkg::PATTERN_OFFSET : 5'h00);
  always_ff @(posedge aclk) begin
    if (!aresetn) pattern_number <= 5'h00;
    else if (st_r == cio_pkg::CIO_ST_IDLE) pattern_number <= pattern_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cascade_mode <= 1'b0;
      program_running <= 1'b0;
    end else begin
      cascade_mode <= db[6];
      program_running <= (st_r == cio_pkg::CIO_ST_RUN);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {time_event_d_out, time_event_c_out, time_event_b_out, time_event_a_out} <= 4'h0;
      {instrument_alarm_out, pv_event_b_out, pv_event_a_out} <= 3'h0;
    end else begin
      {time_event_d_out, time_event_c_out, time_event_b_out, time_event_a_out} <= events_r[6:3];
      {instrument_alarm_out, pv_event_b_out, pv_event_a_out} <= events_r[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) control_output_value <= 16'h0000;
    else if (st_r == cio_pkg::CIO_ST_IDLE) control_output_value <= preset_r;
    else if (manual_r) control_output_value <= manual_val_r;
    else control_output_value <= pid_out_r;
  end

  // both sources, power exclusive; second source retransmission relay only, its loop power not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retrans_first_value <= 16'h0000;
      retrans_first_en <= 1'b0;
      loop_power_first_en <= 1'b0;
      retrans_second_value <= 16'h0000;
      retrans_second_en <= 1'b0;
      loop_power_second_en <= 1'b0;
    end else begin
      case (retrans_first_type_type_r)
        cio_pkg::RET_PV: retrans_first_value <= pv_r;
        cio_pkg::RET_SP: retrans_first_value <= sp_r;
        cio_pkg::RET_CTRL: retrans_first_value <= control_output_value;
        default: retrans_first_value <= 16'h0000;
      endcase
      retrans_first_en <= (retrans_first_type_type_r != cio_pkg::RET_OFF) &&
                          (retrans_first_type_type_r < cio_pkg::RET_LOOP_POWER);
      loop_power_first_en <= (retrans_first_type_type_r == cio_pkg::RET_LOOP_POWER);
      case (retrans_second_type_type_r)
        cio_pkg::RET_PV: retrans_second_value <= pv_r;
        cio_pkg::RET_SP: retrans_second_value <= sp_r;
        cio_pkg::RET_CTRL: retrans_second_value <= control_output_value;
        default: retrans_second_value <= 16'h0000;
      endcase
      retrans_second_en <= kind_relay_r && (retrans_second_type_type_r != cio_pkg::RET_OFF) &&
                           (retrans_second_type_type_r < cio_pkg::RET_LOOP_POWER);
      loop_power_second_en <= (retrans_second_type_type_r == cio_pkg::RET_LOOP_POWER);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pid1_p, pid1_i, pid1_d} <= 48'h0000_0000_0000;
      {pid2_p, pid2_i, pid2_d} <= 48'h0000_0000_0000;
    end else begin
      pid1_p <= pid_mem[{1'b0, grp1_r, 2'd0}];
      pid1_i <= pid_mem[{1'b0, grp1_r, 2'd1}];
      pid1_d <= pid_mem[{1'b0, grp1_r, 2'd2}];
      pid2_p <= pid_mem[{1'b1, grp2_r, 2'd0}];
      pid2_i <= pid_mem[{1'b1, grp2_r, 2'd1}];
      pid2_d <= pid_mem[{1'b1, grp2_r, 2'd2}];
    end
  end

  // pid table cleared by reset, so an unloaded group reads zero, not unknown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < 64; k++) begin
        pid_mem[k] <= 16'h0000;
      end
    end else if (do_write && aw_addr_r[11:8] == cio_pkg::OFS_PID_PAGE) begin
      pid_mem[aw_addr_r[7:2]] <= 16'(merge({16'h0000, pid_mem[aw_addr_r[7:2]]}, w_data_r,
                                           w_strb_r));
    end
  end

  // interrupt events: start, stop, cascade change, pattern change
  assign irq_set = {pattern_nxt != pattern_number && st_r == cio_pkg::CIO_ST_IDLE,
                    db[6] != cascade_mode,
                    st_r == cio_pkg::CIO_ST_RUN && st_nxt == cio_pkg::CIO_ST_IDLE,
                    st_r == cio_pkg::CIO_ST_IDLE && st_nxt == cio_pkg::CIO_ST_RUN};
  assign irq_clr = (do_write && aw_addr_r == cio_pkg::OFS_IRQ_CLR && w_strb_r[0]) ?
                   w_data_r[cio_pkg::IRQ_W-1:0] : '0;
  // set wins over a simultaneous clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // write channel: address and data taken in either order
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_err = !((aw_addr_r[11:8] == cio_pkg::OFS_PID_PAGE) || aw_addr_r <= cio_pkg::OFS_IRQ_EN);
  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= cio_pkg::RST_WORD;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cio_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? cio_pkg::RESP_SLVERR : cio_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software registers; key bits are one-cycle pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {key_run_r, key_stop_r, manual_r, kind_relay_r} <= 4'h0;
      {retrans_first_type_type_r, retrans_second_type_type_r, grp1_r, grp2_r} <= 12'h000;
      {preset_r, manual_val_r, pv_r, sp_r, pid_out_r} <= 80'h0;
      events_r <= 7'h00;
      irq_en_r <= '0;
    end else begin
      key_run_r <= do_write && aw_addr_r == cio_pkg::OFS_CTRL && w_strb_r[0] &&
                   w_data_r[cio_pkg::CTRL_KEY_RUN];
      key_stop_r <= do_write && aw_addr_r == cio_pkg::OFS_CTRL && w_strb_r[0] &&
                    w_data_r[cio_pkg::CTRL_KEY_STOP];
      if (do_write && w_strb_r[0]) begin
        case (aw_addr_r)
          cio_pkg::OFS_CTRL: begin
            manual_r <= w_data_r[cio_pkg::CTRL_MANUAL];
            kind_relay_r <= w_data_r[cio_pkg::CTRL_KIND_RELAY];
          end
          cio_pkg::OFS_RETCFG: begin
            retrans_first_type_type_r <= w_data_r[2:0];
            retrans_second_type_type_r <= w_data_r[cio_pkg::RET_SECOND_LSB +: 3];
          end
          cio_pkg::OFS_EVENTS: events_r <= w_data_r[6:0];
          cio_pkg::OFS_PIDSEL: begin
            grp1_r <= w_data_r[2:0];
            grp2_r <= w_data_r[cio_pkg::PIDSEL_LOOP2_LSB +: 3];
          end
          cio_pkg::OFS_IRQ_EN: irq_en_r <= w_data_r[cio_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end
      if (do_write) begin
        case (aw_addr_r)
          cio_pkg::OFS_PRESET: {manual_val_r, preset_r} <=
            merge({manual_val_r, preset_r}, w_data_r, w_strb_r);
          cio_pkg::OFS_PV: pv_r <= 16'(merge({16'h0000, pv_r}, w_data_r, w_strb_r));
          cio_pkg::OFS_SP: sp_r <= 16'(merge({16'h0000, sp_r}, w_data_r, w_strb_r));
          cio_pkg::OFS_PIDOUT: pid_out_r <= 16'(merge({16'h0000, pid_out_r}, w_data_r,
                                                      w_strb_r));
          default: ;
        endcase
      end
    end
  end

  // read decode; clear register reads zero
  always_comb begin
    rd_word = cio_pkg::RST_WORD;
    rd_err = 1'b0;
    if (s_axi_araddr[11:8] == cio_pkg::OFS_PID_PAGE) begin
      rd_word = {16'h0000, pid_mem[s_axi_araddr[7:2]]};
    end else begin
      case ({s_axi_araddr[11:2], 2'b00})
        cio_pkg::OFS_CTRL: rd_word = {28'h000_0000, kind_relay_r, manual_r, 2'b00};
        cio_pkg::OFS_RETCFG: rd_word = {25'h000_0000, retrans_second_type_type_r, 1'b0, retrans_first_type_type_r};
        cio_pkg::OFS_PRESET: rd_word = {manual_val_r, preset_r};
        cio_pkg::OFS_STATUS: rd_word = {8'h00, db, 6'h00, cascade_mode, program_running,
                                        3'h0, pattern_number};
        cio_pkg::OFS_EVENTS: rd_word = {25'h000_0000, events_r};
        cio_pkg::OFS_PV: rd_word = {16'h0000, pv_r};
        cio_pkg::OFS_SP: rd_word = {16'h0000, sp_r};
        cio_pkg::OFS_PIDOUT: rd_word = {16'h0000, pid_out_r};
        cio_pkg::OFS_PIDSEL: rd_word = {25'h000_0000, grp2_r, 1'b0, grp1_r};
        cio_pkg::OFS_IRQ_STAT: rd_word = {28'h000_0000, irq_stat_r};
        cio_pkg::OFS_IRQ_CLR: rd_word = cio_pkg::RST_WORD;
        cio_pkg::OFS_IRQ_EN: rd_word = {28'h000_0000, irq_en_r};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // read channel: one outstanding read, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= cio_pkg::RST_WORD;
      s_axi_rresp <= cio_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_err ? cio_pkg::RESP_SLVERR : cio_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_stop_seen;
    stop_req ##1 (st_r == cio_pkg::CIO_ST_IDLE);
  endsequence
  sequence s_start_seen;
    (st_r == cio_pkg::CIO_ST_IDLE && run_rise && !stop_req) ##1 (st_r == cio_pkg::CIO_ST_RUN);
  endsequence

  a_pattern_decode: assert property (st_r == cio_pkg::CIO_ST_IDLE |=>
    pattern_number == $past(pattern_nxt)) else $error("pattern number wrong");
  a_pattern_frozen: assert property (st_r == cio_pkg::CIO_ST_RUN |=>
    $stable(pattern_number)) else $error("pattern changed while running");
  a_run_start: assert property (st_r == cio_pkg::CIO_ST_IDLE && run_rise && !stop_req
    |-> s_start_seen) else $error("run edge did not start");
  a_stop_edge: assert property (stop_rise |-> s_stop_seen)
    else $error("stop edge did not stop");
  a_preset_out: assert property (st_r == cio_pkg::CIO_ST_IDLE |=>
    control_output_value == $past(preset_r)) else $error("preset not driven when stopped");
  a_cascade_mode: assert property (1'b1 |=> cascade_mode == $past(db[6]))
    else $error("cascade mode mismatch");
  a_contact_map: assert property (1'b1 |=>
    {time_event_d_out, time_event_c_out, time_event_b_out, time_event_a_out,
     instrument_alarm_out, pv_event_b_out, pv_event_a_out} == $past(events_r))
    else $error("contact output mapping wrong");
  a_pid_group: assert property (1'b1 |=> pid2_d == $past(pid_mem[{1'b1, grp2_r, 2'd2}]))
    else $error("pid group output wrong");
  a_loop_power: assert property (retrans_first_type_type_r == cio_pkg::RET_LOOP_POWER |=>
    loop_power_first_en && !retrans_first_en) else $error("loop power not exclusive");
  a_second_relay: assert property (!kind_relay_r |=> !retrans_second_en)
    else $error("second retransmission without relay");
  a_first_source: assert property (retrans_first_type_type_r == cio_pkg::RET_SP |=>
    retrans_first_value == $past(sp_r)) else $error("first retransmission source wrong");
  a_single_edge: assert property ($changed(db[4]) |=> $stable(db[4]))
    else $error("debounced run level chattered");
endmodule

// ===== design/cio_pkg.sv
package cio_pkg;
  // clock rate and contact debounce time
  localparam int CLK_HZ = 50_000_000;
  localparam int DEBOUNCE_US = 10_000;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int DB_CNT_W = 20;

  // register bus geometry
  localparam int ADDR_W = 12;
  localparam int VAL_W = 16;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_RETCFG = 12'h004;
  localparam logic [11:0] OFS_PRESET = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_EVENTS = 12'h010;
  localparam logic [11:0] OFS_PV = 12'h014;
  localparam logic [11:0] OFS_SP = 12'h018;
  localparam logic [11:0] OFS_PIDOUT = 12'h01c;
  localparam logic [11:0] OFS_PIDSEL = 12'h020;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h024;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h028;
  localparam logic [11:0] OFS_IRQ_EN = 12'h02c;
  localparam logic [3:0] OFS_PID_PAGE = 4'h1;

  // register field bit positions
  localparam int CTRL_KEY_RUN = 0;
  localparam int CTRL_KEY_STOP = 1;
  localparam int CTRL_MANUAL = 2;
  localparam int CTRL_KIND_RELAY = 3;
  localparam int RET_SECOND_LSB = 4;
  localparam int PRESET_MAN_LSB = 16;
  localparam int PIDSEL_LOOP2_LSB = 4;
  localparam int STAT_RUN = 8;
  localparam int STAT_CASCADE = 9;
  localparam int STAT_DI_LSB = 16;

  // retransmission type codes
  localparam logic [2:0] RET_OFF = 3'h0;
  localparam logic [2:0] RET_PV = 3'h1;
  localparam logic [2:0] RET_SP = 3'h2;
  localparam logic [2:0] RET_CTRL = 3'h3;
  localparam logic [2:0] RET_LOOP_POWER = 3'h4;

  // pattern offset contact adds this
  localparam logic [4:0] PATTERN_OFFSET = 5'h10;
  localparam int IRQ_W = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CIO_ST_IDLE = 2'b01,
    CIO_ST_RUN = 2'b10
  } cio_state_t;
endpackage

// ===== design/cio_debounce.sv
`timescale 1ns/10ps
module cio_debounce #(
  parameter int W = 8,
  parameter int CNT_W = 20,
  parameter int CYC = 500_000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] clean_out
);
  // each contact: two-stage sync, then must hold CYC cycles to be taken
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta_r;
    logic sync_r;
    logic [CNT_W-1:0] cnt_r;
    logic clean_r;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
      end else begin
        meta_r <= raw_in[g];
        sync_r <= meta_r;
      end
    end
    // any bounce restarts the count, so one press gives one level change
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_r <= '0;
        clean_r <= 1'b0;
      end else if (sync_r == clean_r) begin
        cnt_r <= '0;
      end else if (cnt_r == CNT_W'(CYC - 1)) begin
        cnt_r <= '0;
        clean_r <= sync_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
    // one driver per bit keeps the vector free of shared writers
    assign clean_out[g] = clean_r;
  end
endmodule

// ===== tb/cio_field.sv
`timescale 1ns/10ps
module cio_field (
  input wire logic aclk,
  input wire logic [7:0] want,
  output logic [7:0] contact
);
  logic [7:0] last_r;
  logic [7:0] flip_r;
  int bounce_r;

  initial begin
    contact = 8'h00;
    last_r = 8'h00;
    flip_r = 8'h00;
    bounce_r = 0;
  end

  // mechanical contact chatter
  // a changed contact chatters once, shorter than the debounce window
  always @(posedge aclk) begin
    if (want !== last_r) begin
      flip_r <= want ^ last_r;
      last_r <= want;
      contact <= want;
      bounce_r <= 3;
    end else if (bounce_r > 0) begin
      contact <= (bounce_r == 1) ? want : contact ^ flip_r;
      bounce_r <= bounce_r - 1;
    end
  end
endmodule

// ===== tb/test_contact_io_program_control.sv
`timescale 1ns/10ps
module test_contact_io_program_control;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, e, pre, tab [8];
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic pv_event_a_out, pv_event_b_out, instrument_alarm_out, time_event_a_out;
  logic time_event_b_out, time_event_c_out, time_event_d_out, program_running, cascade_mode;
  logic retrans_first_en, loop_power_first_en, retrans_second_en, loop_power_second_en;
  logic [15:0] control_output_value, retrans_first_value, retrans_second_value, pid1_p, pid2_d;
  logic [15:0] src [4];
  logic [15:0] pid1_d, pid2_p;
  logic [4:0] pattern_number, p;
  logic [7:0] want, contact;
  int mismatches, num_checks, seed;

  cio_field field (.aclk, .want, .contact);
  cio_top #(.DEBOUNCE_CYCLES(4)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pattern_sel_bit0(contact[0]),
    .pattern_sel_bit1(contact[1]), .pattern_sel_bit2(contact[2]), .pattern_sel_bit3(contact[3]),
    .run_contact(contact[4]), .stop_contact(contact[5]), .cascade_local_contact(contact[6]),
    .pattern_offset_contact(contact[7]), .pv_event_a_out, .pv_event_b_out,
    .instrument_alarm_out, .time_event_a_out, .time_event_b_out, .time_event_c_out,
    .time_event_d_out, .pattern_number, .program_running, .cascade_mode,
    .control_output_value, .retrans_first_value, .retrans_first_en, .loop_power_first_en,
    .retrans_second_value, .retrans_second_en, .loop_power_second_en, .pid1_p, .pid1_i(),
    .pid1_d, .pid2_p, .pid2_i(), .pid2_d, .irq);

  // 50 MHz
  initial aclk = 1'b0;
  always #10 aclk = ~aclk;

  function automatic logic [4:0] exp_pat(input logic [7:0] w);
    return {1'b0, w[3:0]} + (w[7] ? cio_pkg::PATTERN_OFFSET : 5'h00);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n > 100) begin
      mismatches++;
      $display("mismatch at %0t: wait ran out", $time);
      end_sim();
    end
  endtask

  // ends on a falling edge so registered outputs have settled
  task automatic wcyc(input int c);
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask

  // ready and valid are looked at mid-cycle, acted on at the next rising edge
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic aw_go, w_go, b_go;
    n = 0;
    b_go = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_go) begin
      @(negedge aclk);
      aw_go = s_axi_awvalid & s_axi_awready;
      w_go = s_axi_wvalid & s_axi_wready;
      b_go = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
      n++;
      tmo(n);
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a);
    int n;
    logic ar_go, r_go;
    n = 0;
    r_go = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_go) begin
      @(negedge aclk);
      ar_go = s_axi_arvalid & s_axi_arready;
      r_go = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_go) s_axi_arvalid <= 1'b0;
      n++;
      tmo(n);
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (program_running !== v && n <= 100) begin
      @(negedge aclk);
      n++;
    end
    chk(program_running, v);
    tmo(n);
  endtask

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, want} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    seed = 10;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(12'h0f0);
    chk(rsp, cio_pkg::RESP_SLVERR);
    axw(12'h0f0, 32'hffff_ffff);
    chk(rsp, cio_pkg::RESP_SLVERR);
    axr(cio_pkg::OFS_IRQ_EN);
    chk(rd, cio_pkg::RST_WORD);
    $display("test bus done");
    pre = $random(seed);
    axw(cio_pkg::OFS_PRESET, pre);
    axw(cio_pkg::OFS_CTRL, 32'h0000_0004);
    wcyc(2);
    chk(control_output_value, pre[15:0]);
    for (int i = 0; i < 8; i++) begin
      want = (i == 0) ? 8'h8f : (i == 1) ? 8'h40 : 8'($random(seed)) & 8'hcf;
      wcyc(20);
      chk(pattern_number, exp_pat(want));
      chk(cascade_mode, want[6]);
    end
    chk(irq, 1'b0);
    axr(cio_pkg::OFS_IRQ_STAT);
    chk(rd[2], 1'b1);
    $display("test pattern done");
    axw(cio_pkg::OFS_IRQ_CLR, 32'h0000_000f);
    axw(cio_pkg::OFS_IRQ_EN, 32'h0000_0001);
    p = exp_pat(want);
    want = want | 8'h10;
    wait_run(1'b1);
    wcyc(2);
    chk(irq, 1'b1);
    chk(control_output_value, pre[31:16]);
    want = want ^ 8'h8f;
    wcyc(20);
    chk(pattern_number, p);
    axw(cio_pkg::OFS_IRQ_CLR, 32'h0000_0001);
    wcyc(2);
    chk(irq, 1'b0);
    want = want | 8'h20;
    wait_run(1'b0);
    wcyc(2);
    chk(control_output_value, pre[15:0]);
    chk(pattern_number, exp_pat(want));
    axr(cio_pkg::OFS_IRQ_STAT);
    chk(rd[1:0], 2'b10);
    want = want & 8'hcf;
    $display("test run done");
    repeat (4) begin
      e = $random(seed);
      axw(cio_pkg::OFS_EVENTS, {25'h0, e[6:0]});
      wcyc(2);
      chk({time_event_d_out, time_event_c_out, time_event_b_out, time_event_a_out,
        instrument_alarm_out, pv_event_b_out, pv_event_a_out}, e[6:0]);
    end
    e = $random(seed);
    src[0] = 16'h0000;
    src[1] = e[15:0];
    src[2] = e[31:16];
    src[3] = pre[15:0];
    axw(cio_pkg::OFS_PV, {16'h0000, src[1]});
    axw(cio_pkg::OFS_SP, {16'h0000, src[2]});
    axw(cio_pkg::OFS_CTRL, 32'h0000_000c);
    for (int t = 0; t < 5; t++) begin
      axw(cio_pkg::OFS_RETCFG, {25'h0, t[2:0], 1'b0, t[2:0]});
      wcyc(2);
      chk(loop_power_first_en, t == 4);
      chk(retrans_first_en, t inside {[1:3]});
      chk(retrans_second_en, t inside {[1:3]});
      chk(loop_power_second_en, t == 4);
      if (t inside {[1:3]}) chk(retrans_first_value, src[t]);
      if (t inside {[1:3]}) chk(retrans_second_value, src[t]);
    end
    axw(cio_pkg::OFS_CTRL, 32'h0000_0004);
    axw(cio_pkg::OFS_RETCFG, 32'h0000_0010);
    wcyc(2);
    chk(retrans_second_en, 1'b0);
    // key run, then key stop brings preset back over manual
    axw(cio_pkg::OFS_CTRL, 32'h0000_0005);
    wait_run(1'b1);
    wcyc(2);
    chk(control_output_value, pre[31:16]);
    axw(cio_pkg::OFS_CTRL, 32'h0000_0006);
    wait_run(1'b0);
    wcyc(2);
    chk(control_output_value, pre[15:0]);
    $display("test outputs done");
    for (int g = 0; g < 8; g++) begin
      tab[g] = $random(seed);
      axw(12'h100 + 12'(g * 16), {16'h0000, tab[g][15:0]});
      axw(12'h188 + 12'(g * 16), {16'h0000, tab[g][31:16]});
    end
    for (int g = 7; g >= 0; g--) begin
      axw(cio_pkg::OFS_PIDSEL, {25'h0, g[2:0], 1'b0, g[2:0]});
      wcyc(2);
      chk(pid1_p, tab[g][15:0]);
      chk(pid2_d, tab[g][31:16]);
      chk(pid2_p, 16'h0000);
      chk(pid1_d, 16'h0000);
    end
    $display("test pid done");
    end_sim();
  end
endmodule
